// file: pkg/ccp_pkg.sv
// clock control package: register map, fields, resets, timing, types
// assumes a 10 MHz block clock and a byte-wide control port
//
// Operation
// RL1: host sets core clock gate, bit 0 of 0x00, when a crystal is used
// RL2: host programs the PLL output to exactly 24.576 MHz
// RL3: source clock may bypass the PLL when it is 12.288 or 24.576 MHz
// RL4: host sets both halvers so master and core clocks are 12.288 MHz
// RL5: halvers at 1 divide by one, halvers at 0 divide by two
// RL6: halvers fixed after setup; source select may change while running
// RL7: after power-up internal reset is held, then released after 15 ms
// RL8: core clock gate resets clear; clear stops, set starts the clock
// RL9: host keeps gate clear until lock bit in 0x06 is reported
// RL10: host clears PLL on, writes 0x01..0x05, sets PLL on, polls lock
// RL11: during lock acquisition host touches only registers 0x00..0x06
// RL12: host clears run bit in 0x09 before changing decimator or feed
// RL13: reference passes an integer predivider X+1, X in 0x05 bits 2:1
// RL14: integer mode multiplies by R/2, numerator and denominator ignored
// RL15: fractional mode multiplies by half of R plus N/M
// RL16: host keeps N/M between 0.1 and 0.9 in fractional mode
// RL17: host keeps PLL output between 20.5 MHz and 27 MHz
// RL18: PLL reference of 8 to 27 MHz comes from the master clock input
// RL19: clock output is master clock times 2, 1, 1/2, 1/4 or 1/8
// RL20: in PDM mode only the 1/2, 1/4 and 1/8 settings give a clock
// RL21: host picks times two only when master halver divides by two
// RL22: 0x05 holds R above the predivider field; 0x20 means R=4, X+1=1
// RL23: 0x01/0x02 hold M high/low, 0x03/0x04 hold N high/low
// RL24: lock reads clear while PLL is off, set only once output settles

package ccp_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int FRAC_W = 16;
   localparam int RINT_W = 4;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CLK_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_DEN_HI    = 8'h01;
   localparam logic [7:0] ADDR_DEN_LO    = 8'h02;
   localparam logic [7:0] ADDR_NUM_HI    = 8'h03;
   localparam logic [7:0] ADDR_NUM_LO    = 8'h04;
   localparam logic [7:0] ADDR_PLL_RATIO = 8'h05;
   localparam logic [7:0] ADDR_LOCK      = 8'h06;
   localparam logic [7:0] ADDR_CLOCK_OUTPUT_PIN    = 8'h07;
   localparam logic [7:0] ADDR_CORE_RUN  = 8'h09;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_GATE     = 0;
   localparam int BIT_MDIV     = 1;
   localparam int BIT_CDIV     = 2;
   localparam int BIT_SRC      = 3;
   localparam int BIT_PLL_EN   = 7;
   localparam int BIT_FRAC     = 0;
   localparam int PDIV_LSB     = 1;
   localparam int PDIV_MSB     = 2;
   localparam int RINT_LSB     = 3;
   localparam int RINT_MSB     = 6;
   localparam int BIT_LOCK     = 0;
   localparam int CO_SEL_LSB   = 0;
   localparam int CO_SEL_MSB   = 2;
   localparam int BIT_PDM      = 3;
   localparam int BIT_CORE_RUN = 0;

   // ------------------------------------------------------------
   // reset values and masks
   // ------------------------------------------------------------
   localparam logic [7:0]  CLK_CTRL_RST  = 8'h00;
   localparam logic [7:0]  CLK_CTRL_MASK = 8'h8f;
   localparam logic [7:0]  RATIO_RST     = 8'h00;
   localparam logic [7:0]  RATIO_MASK    = 8'h7f;
   localparam logic [15:0] FRAC_RST      = 16'h0000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_KHZ     = 10000;
   localparam int POR_TIME_MS      = 15;
   localparam int POR_CYCLES_DFLT  = POR_TIME_MS * CLK_FREQ_KHZ;
   localparam int LOCK_CYCLES_DFLT = 64;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CO_X2      = 3'b000,
      CO_X1      = 3'b001,
      CO_HALF    = 3'b010,
      CO_QUARTER = 3'b011,
      CO_EIGHTH  = 3'b100
   } ccp_clock_output_pin_type;

   typedef enum logic [1:0] {
      PLL_OFF    = 2'b00,
      PLL_WAIT   = 2'b01,
      PLL_LOCKED = 2'b10
   } ccp_pll_type;
endpackage

// file: design/ccp_clock_output_pin.sv
// clock output pin generator
// assumes master and source ticks already gated by the core clock gate
`timescale 1ns/1ns
`default_nettype none

module ccp_clock_output_pin (
   // clock and reset
   input  wire logic                    mclk_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   // ticks
   input  wire logic                    src_hit_i,
   input  wire logic                    mst_hit_i,
   input  wire logic                    x2_ok_i,
   // configuration
   input  wire ccp_pkg::ccp_clock_output_pin_type sel_i,
   input  wire logic                    pdm_i,
   // pin
   output var  logic                    pin_o
);
   import ccp_pkg::*;

   logic [2:0] div_cnt;
   logic [2:0] next_div_cnt;
   logic       next_pin;
   logic       tgl;

   // ------------------------------------------------------------
   // toggle selection
   // ------------------------------------------------------------
   always_comb begin
      next_div_cnt = mst_hit_i ? div_cnt + 3'h1 : div_cnt;
      tgl = 1'b0;
      case (sel_i)
         CO_X2:      tgl = src_hit_i & x2_ok_i & ~pdm_i;     // RL19 RL20
         CO_X1:      tgl = mst_hit_i & ~pdm_i;               // RL19 RL20
         CO_HALF:    tgl = mst_hit_i & div_cnt[0];           // RL19
         CO_QUARTER: tgl = mst_hit_i & (&div_cnt[1:0]);      // RL19
         CO_EIGHTH:  tgl = mst_hit_i & (&div_cnt);           // RL19
         default:    tgl = 1'b0;
      endcase
      next_pin = tgl ? ~pin_o : pin_o;
      if (pdm_i && (sel_i == CO_X2 || sel_i == CO_X1)) begin
         next_pin = 1'b0;                                    // RL20
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         div_cnt <= 3'h0;
         pin_o   <= 1'b0;
      end else if (ce_i) begin
         div_cnt <= next_div_cnt;
         pin_o   <= next_pin;
      end
   end

   pdm_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RL20
      ce_i && pdm_i && sel_i == CO_X1 |=> !pin_o)
      else $error("clock output runs in pdm mode at times one");

endmodule // ccp_clock_output_pin

`default_nettype wire

// file: design/ccp_clock_init.sv
// clock gating, halvers, PLL setup and power-up hold
// assumes source and PLL clocks arrive as one-cycle ticks on mclk_i
`timescale 1ns/1ns
`default_nettype none

module ccp_clock_init #(
   parameter int unsigned POR_CYCLES  = ccp_pkg::POR_CYCLES_DFLT,
   parameter int unsigned LOCK_CYCLES = ccp_pkg::LOCK_CYCLES_DFLT
) (
   // clock and reset
   input  wire logic                        mclk_i,
   input  wire logic                        rst_i,
   input  wire logic                        ce_i,
   // control port
   input  wire logic                        wr_en_i,
   input  wire logic                        rd_en_i,
   input  wire logic [ccp_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic [ccp_pkg::DATA_W-1:0]  wdata_i,
   output var  logic [ccp_pkg::DATA_W-1:0]  rdata_o,
   output var  logic                        rvalid_o,
   // clocks in
   input  wire logic                        src_tick_i,
   input  wire logic                        pll_tick_i,
   input  wire logic                        pll_settled_i,
   // PLL controls
   output var  logic                        pll_en_o,
   output var  logic                        pll_ref_tick_o,
   output var  logic                        pll_frac_o,
   output var  logic [ccp_pkg::RINT_W-1:0]  pll_int_o,
   output var  logic [ccp_pkg::FRAC_W-1:0]  pll_num_o,
   output var  logic [ccp_pkg::FRAC_W-1:0]  pll_den_o,
   // internal clocks and status
   output var  logic                        int_rst_o,
   output var  logic                        core_clock_gate_o,
   output var  logic                        mst_tick_o,
   output var  logic                        core_tick_o,
   output var  logic                        core_run_o,
   output var  logic                        clock_output_pin_o
);
   import ccp_pkg::*;

   localparam int PW = $clog2(POR_CYCLES + 1);
   localparam int LW = $clog2(LOCK_CYCLES + 1);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [7:0]          clk_ctrl, next_clk_ctrl;
   logic [7:0]          ratio, next_ratio;
   logic [15:0]         den, next_den;
   logic [15:0]         num, next_num;
   ccp_clock_output_pin_type      co_sel, next_co_sel;
   logic                pdm, next_pdm;
   logic                next_core_run;
   logic [7:0]          next_rdata;
   logic                next_rvalid;
   logic                locked;
   ccp_pll_type         pll_st, next_pll_st;

   assign locked = (pll_st == PLL_LOCKED);

   always_comb begin
      next_clk_ctrl = clk_ctrl;
      next_ratio    = ratio;
      next_den      = den;
      next_num      = num;
      next_co_sel   = co_sel;
      next_pdm      = pdm;
      next_core_run = core_run_o;
      next_rvalid   = rd_en_i & ~int_rst_o;
      next_rdata    = 8'h00;
      if (int_rst_o) begin
         next_clk_ctrl = CLK_CTRL_RST;                          // RL7 RL8
         next_ratio    = RATIO_RST;
         next_den      = FRAC_RST;
         next_num      = FRAC_RST;
         next_co_sel   = CO_X2;
         next_pdm      = 1'b0;
         next_core_run = 1'b0;
      end else if (wr_en_i) begin
         case (addr_i)
            ADDR_CLK_CTRL:  next_clk_ctrl = wdata_i & CLK_CTRL_MASK; // RL6
            ADDR_DEN_HI:    next_den[15:8] = wdata_i;           // RL23
            ADDR_DEN_LO:    next_den[7:0]  = wdata_i;           // RL23
            ADDR_NUM_HI:    next_num[15:8] = wdata_i;           // RL23
            ADDR_NUM_LO:    next_num[7:0]  = wdata_i;           // RL23
            ADDR_PLL_RATIO: next_ratio = wdata_i & RATIO_MASK;  // RL22
            ADDR_CLOCK_OUTPUT_PIN: begin
               next_co_sel =
                  ccp_clock_output_pin_type'(wdata_i[CO_SEL_MSB:CO_SEL_LSB]);
               next_pdm    = wdata_i[BIT_PDM];
            end
            ADDR_CORE_RUN:  next_core_run = wdata_i[BIT_CORE_RUN];
            default: ;
         endcase
      end
      if (rd_en_i) begin
         case (addr_i)
            ADDR_CLK_CTRL:  next_rdata = clk_ctrl;
            ADDR_DEN_HI:    next_rdata = den[15:8];
            ADDR_DEN_LO:    next_rdata = den[7:0];
            ADDR_NUM_HI:    next_rdata = num[15:8];
            ADDR_NUM_LO:    next_rdata = num[7:0];
            ADDR_PLL_RATIO: next_rdata = ratio;
            ADDR_LOCK:      next_rdata = {7'h00, locked};       // RL24
            ADDR_CLOCK_OUTPUT_PIN:    next_rdata = {4'h0, pdm, co_sel};
            ADDR_CORE_RUN:  next_rdata = {7'h00, core_run_o};
            default:        next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         clk_ctrl   <= CLK_CTRL_RST;                            // RL8
         ratio      <= RATIO_RST;
         den        <= FRAC_RST;
         num        <= FRAC_RST;
         co_sel     <= CO_X2;
         pdm        <= 1'b0;
         core_run_o <= 1'b0;
         rdata_o    <= 8'h00;
         rvalid_o   <= 1'b0;
      end else if (ce_i) begin
         clk_ctrl   <= next_clk_ctrl;
         ratio      <= next_ratio;
         den        <= next_den;
         num        <= next_num;
         co_sel     <= next_co_sel;
         pdm        <= next_pdm;
         core_run_o <= next_core_run;
         rdata_o    <= next_rdata;
         rvalid_o   <= next_rvalid;
      end
   end

   assign core_clock_gate_o = clk_ctrl[BIT_GATE];
   assign pll_en_o          = clk_ctrl[BIT_PLL_EN];

   // ------------------------------------------------------------
   // power-up hold and PLL lock tracking
   // ------------------------------------------------------------
   logic [PW-1:0] por_cnt, next_por_cnt;
   logic          next_int_rst;
   logic [LW-1:0] lock_cnt, next_lock_cnt;

   always_comb begin
      next_por_cnt  = por_cnt;
      next_int_rst  = 1'b1;
      if (por_cnt != PW'(POR_CYCLES)) begin
         next_por_cnt = por_cnt + PW'(1);                       // RL7
      end
      if (next_por_cnt == PW'(POR_CYCLES)) begin
         next_int_rst = 1'b0;                                   // RL7
      end
      next_pll_st   = pll_st;
      next_lock_cnt = lock_cnt;
      case (pll_st)
         PLL_OFF: begin
            next_lock_cnt = '0;
            if (pll_en_o) begin
               next_pll_st = PLL_WAIT;
            end
         end
         PLL_WAIT: begin
            if (!pll_settled_i) begin
               next_lock_cnt = '0;
            end else if (lock_cnt == LW'(LOCK_CYCLES - 1)) begin
               next_pll_st = PLL_LOCKED;                        // RL24
            end else begin
               next_lock_cnt = lock_cnt + LW'(1);
            end
         end
         PLL_LOCKED: begin
            if (!pll_settled_i) begin
               next_pll_st   = PLL_WAIT;
               next_lock_cnt = '0;
            end
         end
         default: next_pll_st = PLL_OFF;
      endcase
      if (!pll_en_o) begin
         next_pll_st = PLL_OFF;                                 // RL24
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         por_cnt   <= '0;
         int_rst_o <= 1'b1;
         pll_st    <= PLL_OFF;
         lock_cnt  <= '0;
      end else if (ce_i) begin
         por_cnt   <= next_por_cnt;
         int_rst_o <= next_int_rst;
         pll_st    <= next_pll_st;
         lock_cnt  <= next_lock_cnt;
      end
   end

   // ------------------------------------------------------------
   // predivider, halvers and clock gating
   // ------------------------------------------------------------
   logic [1:0] pre_cnt, next_pre_cnt;
   logic       mph, next_mph;
   logic       cph, next_cph;
   logic       sel_tick, pre_hit, mst_hit, core_hit;
   logic       next_ref, next_mst, next_core;

   always_comb begin
      sel_tick = clk_ctrl[BIT_SRC] ? pll_tick_i : src_tick_i; // RL3 RL6
      pre_hit  = src_tick_i & (pre_cnt == ratio[PDIV_MSB:PDIV_LSB]);
      next_pre_cnt = pre_cnt;
      if (!pll_en_o || pre_hit) begin
         next_pre_cnt = 2'h0;                                   // RL13
      end else if (src_tick_i) begin
         next_pre_cnt = pre_cnt + 2'h1;                         // RL13 RL18
      end
      next_ref = pll_en_o & pre_hit;                            // RL13
      mst_hit  = sel_tick & (clk_ctrl[BIT_MDIV] | mph);         // RL5
      core_hit = sel_tick & (clk_ctrl[BIT_CDIV] | cph);         // RL5
      next_mph = sel_tick ? ~mph : mph;
      next_cph = sel_tick ? ~cph : cph;
      next_mst  = core_clock_gate_o & mst_hit;                  // RL8
      next_core = core_clock_gate_o & core_hit;                 // RL8
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_cnt        <= 2'h0;
         mph            <= 1'b0;
         cph            <= 1'b0;
         pll_ref_tick_o <= 1'b0;
         mst_tick_o     <= 1'b0;
         core_tick_o    <= 1'b0;
         pll_frac_o     <= 1'b0;
         pll_int_o      <= '0;
         pll_num_o      <= '0;
         pll_den_o      <= '0;
      end else if (ce_i) begin
         pre_cnt        <= next_pre_cnt;
         mph            <= next_mph;
         cph            <= next_cph;
         pll_ref_tick_o <= next_ref;
         mst_tick_o     <= next_mst;
         core_tick_o    <= next_core;
         pll_frac_o     <= ratio[BIT_FRAC];                     // RL22
         pll_int_o      <= ratio[RINT_MSB:RINT_LSB];            // RL22
         pll_num_o      <= ratio[BIT_FRAC] ? num : '0;          // RL14 RL15
         pll_den_o      <= den;                                 // RL15
      end
   end

   ccp_clock_output_pin u_clock_output_pin (
      .mclk_i    (mclk_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .src_hit_i (sel_tick & core_clock_gate_o),
      .mst_hit_i (next_mst),
      .x2_ok_i   (~clk_ctrl[BIT_MDIV]),
      .sel_i     (co_sel),
      .pdm_i     (pdm),
      .pin_o     (clock_output_pin_o)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   por_read_block_a: assert property ( // RL7
      int_rst_o && rd_en_i |=> !rvalid_o)
      else $error("register read answered during power-up hold");
   gate_after_por_a: assert property ( // RL8
      $fell(int_rst_o) |-> !core_clock_gate_o)
      else $error("core clock gate not clear after power-up hold");
   gate_stops_a: assert property ( // RL8
      ce_i && !core_clock_gate_o |=> !mst_tick_o && !core_tick_o)
      else $error("internal clock runs with gate clear");
   bypass_pass_a: assert property ( // RL3
      ce_i && core_clock_gate_o && !clk_ctrl[BIT_SRC]
      && clk_ctrl[BIT_MDIV] && src_tick_i |=> mst_tick_o)
      else $error("bypassed source tick lost");
   halver_skip_a: assert property ( // RL5
      ce_i && !clk_ctrl[BIT_MDIV] && sel_tick && !mph |=> !mst_tick_o)
      else $error("halver did not drop alternate tick");
   prediv_skip_a: assert property ( // RL13
      ce_i && src_tick_i && pre_cnt != ratio[PDIV_MSB:PDIV_LSB]
      |=> !pll_ref_tick_o)
      else $error("predivider passed a tick early");
   int_mode_a: assert property ( // RL14
      ce_i && !ratio[BIT_FRAC] |=> pll_num_o == 16'h0000)
      else $error("numerator leaks in integer mode");
   frac_mode_a: assert property ( // RL15
      ce_i && ratio[BIT_FRAC] |=> pll_num_o == $past(num))
      else $error("numerator missing in fractional mode");
   lock_off_a: assert property ( // RL24
      ce_i && !pll_en_o |=> !locked)
      else $error("lock shown with PLL off");
   lock_settle_a: assert property ( // RL24
      $rose(locked) |-> $past(pll_settled_i) && $past(pll_en_o))
      else $error("lock set without settled PLL");
   den_write_a: assert property ( // RL23
      ce_i && !int_rst_o && wr_en_i && addr_i == ADDR_DEN_LO
      |=> den[7:0] == $past(wdata_i))
      else $error("denominator low byte not stored");

   lock_seen_c: cover property ($rose(locked));
   core_start_c: cover property (locked ##1 $rose(core_clock_gate_o));
   clock_output_pin_run_c: cover property ($rose(clock_output_pin_o));

endmodule // ccp_clock_init

`default_nettype wire

// file: testbench/ccp_pll_model.sv
// model of the external clock source and the analog PLL
// assumes it shares mclk_i with the block and sees its PLL turn-on
`timescale 1ns/1ns
`default_nettype none

module ccp_pll_model #(
   parameter int SETTLE = 10
) (
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // from the block
   input  wire logic pll_en_i,
   // to the block
   output var  logic src_tick_o,
   output var  logic pll_tick_o,
   output var  logic pll_settled_o
);
   logic [1:0] phase;
   int         wait_cnt;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         phase         <= 2'h0;
         wait_cnt      <= 0;
         src_tick_o    <= 1'b0;
         pll_tick_o    <= 1'b0;
         pll_settled_o <= 1'b0;
      end else begin
         phase         <= phase + 2'h1;
         src_tick_o    <= (phase == 2'h3);
         pll_tick_o    <= pll_settled_o && phase[0];
         pll_settled_o <= pll_en_i && (wait_cnt >= SETTLE);
         wait_cnt      <= pll_en_i ? wait_cnt + 1 : 0;
      end
   end
endmodule // ccp_pll_model

`default_nettype wire

// file: testbench/tb_codec_clock_pll_init.sv
// self-checking bench for the clock init block
// assumes the PLL model as clock source, short power-up and lock counts
`timescale 1ns/1ns
`default_nettype none

module tb_codec_clock_pll_init;
   import ccp_pkg::*;
   localparam int POR = 20;
   localparam logic [7:0] CO_SET [8] =
      '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h0b, 8'h09, 8'h0a};
   localparam int CO_EXP [8] = '{64, 32, 16, 8, 0, 16, 0, 32};
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        wr_en_i = 1'b0;
   logic        rd_en_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic [7:0]  rdata_o, r;
   logic        rvalid_o, src_tick_i, pll_tick_i, pll_settled_i;
   logic        pll_en_o, pll_ref_tick_o, pll_frac_o, int_rst_o;
   logic [3:0]  pll_int_o;
   logic [15:0] pll_num_o, pll_den_o;
   logic        core_clock_gate_o, mst_tick_o, core_tick_o;
   logic        core_run_o, clock_output_pin_o, pin_q;
   int          fails = 0, n_tests = 0, cycles = 0;
   int          seed = 32'hec074a24;
   int          n_mst, n_core, n_ref, n_pin;
   logic [7:0]  exp_q [$];

   always #50 mclk_i = ~mclk_i;

   ccp_clock_init #(.POR_CYCLES(POR), .LOCK_CYCLES(4)) dut (
      .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
      .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .src_tick_i(src_tick_i), .pll_tick_i(pll_tick_i),
      .pll_settled_i(pll_settled_i), .pll_en_o(pll_en_o),
      .pll_ref_tick_o(pll_ref_tick_o), .pll_frac_o(pll_frac_o),
      .pll_int_o(pll_int_o), .pll_num_o(pll_num_o),
      .pll_den_o(pll_den_o), .int_rst_o(int_rst_o),
      .core_clock_gate_o(core_clock_gate_o), .mst_tick_o(mst_tick_o),
      .core_tick_o(core_tick_o), .core_run_o(core_run_o),
      .clock_output_pin_o(clock_output_pin_o));

   ccp_pll_model #(.SETTLE(10)) model (
      .mclk_i(mclk_i), .rst_i(rst_i), .pll_en_i(pll_en_o),
      .src_tick_o(src_tick_i), .pll_tick_o(pll_tick_i),
      .pll_settled_o(pll_settled_i));

   task automatic chk(input logic [15:0] got, input logic [15:0] e,
                      input string m);
      n_tests++;
      if (got !== e) begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, e);
      end
   endtask

   task automatic near(input int got, input int e, input string m);
      n_tests++;
      if (got < e - 2 || got > e + 2) begin
         fails++;
         $display("wrong value at %0t: %s got %0d exp %0d", $time, m, got, e);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_en_i <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_en_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      rd_en_i <= 1'b1;
      addr_i  <= a;
      exp_q.push_back(e);
      @(posedge mclk_i);
      rd_en_i <= 1'b0;
   endtask

   task automatic window(input int n);
      @(posedge mclk_i);
      n_mst  = 0;
      n_core = 0;
      n_ref  = 0;
      n_pin  = 0;
      repeat (n) @(posedge mclk_i);
   endtask

   // read answers, tick counters and the hang limit
   always @(negedge mclk_i) begin
      cycles++;
      if (rvalid_o === 1'b1) begin
         if (exp_q.size() == 0)
            chk(16'h1, 16'h0, "unexpected read answer");
         else
            chk(rdata_o, exp_q.pop_front(), "read data");
      end
      n_mst  += (mst_tick_o === 1'b1);
      n_core += (core_tick_o === 1'b1);
      n_ref  += (pll_ref_tick_o === 1'b1);
      n_pin  += (clock_output_pin_o !== pin_q);
      pin_q  = clock_output_pin_o;
      if (cycles > 10000) begin
         fails++;
         finish_test();
      end
   end

   initial begin
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (POR - 1) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(int_rst_o, 1'b1, "hold");
      @(negedge mclk_i);
      chk(int_rst_o, 1'b0, "release");
      $display("test power-up done");
      rd(ADDR_CLK_CTRL, 8'h00);
      rd(ADDR_PLL_RATIO, 8'h00);
      wr(ADDR_CLK_CTRL, 8'h70);
      rd(ADDR_CLK_CTRL, 8'h00);
      wr(8'h08, 8'hff);
      rd(8'h08, 8'h00);
      wr(ADDR_LOCK, 8'hff);
      rd(ADDR_LOCK, 8'h00);
      wr(ADDR_CORE_RUN, 8'h01);
      rd(ADDR_CORE_RUN, 8'h01);
      chk(core_run_o, 1'b1, "run");
      for (int i = 1; i < 5; i++) begin
         r = 8'($random(seed));
         wr(8'(i), r);
         rd(8'(i), r);
      end
      wr(ADDR_DEN_HI, 8'h00);
      wr(ADDR_DEN_LO, 8'h7d);
      wr(ADDR_NUM_HI, 8'h00);
      wr(ADDR_NUM_LO, 8'h12);
      wr(ADDR_PLL_RATIO, 8'h33);
      repeat (2) @(negedge mclk_i);
      chk(pll_den_o, 16'd125, "den");
      chk(pll_num_o, 16'd18, "num");
      chk(pll_frac_o, 1'b1, "frac");
      chk(pll_int_o, 4'd6, "r");
      $display("test registers done");
      wr(ADDR_CLK_CTRL, 8'h80);
      rd(ADDR_LOCK, 8'h00);
      chk(pll_en_o, 1'b1, "pll on");
      window(256);
      near(n_ref, 32, "predivide");
      rd(ADDR_LOCK, 8'h01);
      wr(ADDR_CLK_CTRL, 8'h00);
      rd(ADDR_LOCK, 8'h00);
      wr(ADDR_PLL_RATIO, 8'h20);
      repeat (2) @(negedge mclk_i);
      chk(pll_int_o, 4'd4, "r int");
      chk(pll_frac_o, 1'b0, "int");
      chk(pll_num_o, 16'd0, "num ignored");
      wr(ADDR_CLK_CTRL, 8'h80);
      window(200);
      near(n_mst, 0, "gate off");
      rd(ADDR_LOCK, 8'h01);
      $display("test pll done");
      wr(ADDR_CLK_CTRL, 8'h87);
      window(200);
      chk(core_clock_gate_o, 1'b1, "gate");
      near(n_mst, 50, "master by one");
      near(n_core, 50, "core by one");
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CLOCK_OUTPUT_PIN, CO_SET[i]);
         window(256);
         near(n_pin, CO_EXP[i], "clock out");
      end
      wr(ADDR_CLK_CTRL, 8'h8f);
      window(256);
      near(n_mst, 128, "source switch");
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (POR + 1) @(posedge mclk_i);
      chk(int_rst_o, 1'b0, "second release");
      rd(ADDR_CLK_CTRL, 8'h00);
      wr(ADDR_PLL_RATIO, 8'h20);
      wr(ADDR_CLK_CTRL, 8'h88);
      window(40);
      near(n_ref, 10, "predivide by one");
      rd(ADDR_LOCK, 8'h01);
      wr(ADDR_CLK_CTRL, 8'h89);
      wr(ADDR_CLOCK_OUTPUT_PIN, 8'h00);
      window(256);
      near(n_mst, 64, "master by two");
      near(n_core, 64, "core by two");
      near(n_pin, 128, "clock out x2");
      wr(ADDR_CLOCK_OUTPUT_PIN, 8'h08);
      window(64);
      near(n_pin, 0, "pdm x2 quiet");
      $display("test clocks done");
      repeat (3) @(posedge mclk_i);
      finish_test();
   end
endmodule // tb_codec_clock_pll_init

`default_nettype wire
